// [vlsd_top.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
package vlsd_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TABLE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_WORD = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [3:0] RUNLEN_MAX = 4'h8;
  localparam logic [2:0] TABLE_LAST = 3'h7;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [6:0] WIDTH_ONE = 7'h01;
  localparam logic [6:0] WIDTH_TWO = 7'h02;
  localparam int VALUE_W = 16;

  typedef struct packed {
    logic runin_polarity_bit;
    logic rsvd14;
    logic circ_en;
    logic [4:0] uniform_width_field;
    logic uniform_en;
    logic term_en;
    logic readback;
    logic table_load;
    logic rsvd3;
    logic [2:0] start_index;
  } vlsd_ctrl_t;

  typedef struct packed {
    logic term_flag;
    logic [6:0] pow_width;
  } vlsd_entry_t;

  typedef enum logic [1:0] {
    ST_RUNIN = 2'h0,
    ST_SUFFIX = 2'h1,
    ST_EMIT = 2'h3
  } vlsd_state_t;
endpackage

`timescale 1ns/10ps
module vlsd_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [vlsd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vlsd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  vlsd_pkg::vlsd_ctrl_t ctrl, next_ctrl;
  vlsd_pkg::vlsd_entry_t tbl [8];
  vlsd_pkg::vlsd_entry_t next_tbl [8];
  logic [2:0] wr_idx, next_wr_idx;
  logic [2:0] rd_idx, next_rd_idx;
  logic [31:0] word, next_word;
  logic [5:0] bits_left, next_bits_left;
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [vlsd_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, do_read;
  logic wr_ctrl, wr_table, wr_word, rd_data;
  logic word_ok;
  vlsd_pkg::vlsd_state_t state, next_state;
  logic [3:0] runlen, next_runlen;
  logic [15:0] base, next_base;
  logic [15:0] sfx, next_sfx;
  logic [6:0] rem, next_rem;
  logic take;
  logic dec_en;
  logic bit_avail;
  logic cur_bit;
  logic run_bit;
  vlsd_pkg::vlsd_entry_t ent;
  logic [6:0] width;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_out_data;

  // ----------------------------------------
  // value buffer toward the reader
  // ----------------------------------------
  vlsd_fifo #(
    .WIDTH(vlsd_pkg::VALUE_W)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(state == vlsd_pkg::ST_EMIT),
    .in_ready(fifo_in_ready),
    .in_data(base + sfx),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl = do_write && (aw_addr == vlsd_pkg::ADDR_CTRL);
  assign wr_table = do_write && (aw_addr == vlsd_pkg::ADDR_TABLE) && w_strb[0];
  assign word_ok = (bits_left == 6'h00);
  assign wr_word = do_write && (aw_addr == vlsd_pkg::ADDR_WORD) && word_ok;
  assign rd_data = do_read && (s_axi_araddr == vlsd_pkg::ADDR_DATA);
  assign fifo_pop = rd_data && !ctrl.readback && fifo_out_valid;

  // ----------------------------------------
  // registers and table
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_tbl = tbl;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_word = word;
    next_bits_left = bits_left;
    if (wr_ctrl) begin
      if (w_strb[0]) begin
        next_ctrl[7:0] = w_data[7:0];
      end
      if (w_strb[1]) begin
        next_ctrl[15:8] = w_data[15:8];
      end
      next_ctrl.rsvd14 = 1'b0;
      next_ctrl.rsvd3 = 1'b0;
      if (next_ctrl.table_load) begin
        next_wr_idx = '0;
      end
      if (next_ctrl.readback) begin
        next_rd_idx = '0;
      end
    end
    if (wr_table) begin
      next_tbl[wr_idx] = w_data[7:0];
      next_wr_idx = wr_idx + 3'h1;
    end
    if (rd_data && ctrl.readback) begin
      next_rd_idx = rd_idx + 3'h1;
    end
    if (take) begin
      next_word = {1'b0, word[31:1]};
      next_bits_left = bits_left - 6'h01;
    end
    if (wr_word) begin
      next_word = w_data;
      next_bits_left = vlsd_pkg::WORD_BITS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl <= vlsd_pkg::CTRL_RESET;
      for (int i = 0; i < 8; i++) begin
        tbl[i] <= '0;
      end
      wr_idx <= '0;
      rd_idx <= '0;
      word <= '0;
      bits_left <= '0;
    end else begin
      ctrl <= next_ctrl;
      tbl <= next_tbl;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      word <= next_word;
      bits_left <= next_bits_left;
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        vlsd_pkg::ADDR_CTRL: next_bresp = vlsd_pkg::RESP_OKAY;
        vlsd_pkg::ADDR_TABLE: next_bresp = vlsd_pkg::RESP_OKAY;
        vlsd_pkg::ADDR_WORD: begin
          next_bresp = word_ok ? vlsd_pkg::RESP_OKAY : vlsd_pkg::RESP_SLVERR;
        end
        default: next_bresp = vlsd_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = vlsd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        vlsd_pkg::ADDR_CTRL: next_rdata = {16'h0000, ctrl};
        vlsd_pkg::ADDR_TABLE: next_rdata = '0;
        vlsd_pkg::ADDR_DATA: begin
          if (ctrl.readback) begin
            next_rdata = {24'h000000, tbl[rd_idx]};
          end else begin
            next_rdata = {fifo_out_valid, 15'h0000, fifo_out_data};
          end
        end
        vlsd_pkg::ADDR_WORD: next_rdata = word;
        vlsd_pkg::ADDR_STATUS: begin
          next_rdata = {16'h0000, 4'h0, fifo_out_valid, fifo_in_ready, state, bits_left, 2'h0};
        end
        default: begin
          next_rdata = '0;
          next_rresp = vlsd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vlsd_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= vlsd_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // symbol decoder
  // ----------------------------------------
  assign dec_en = !ctrl.readback && !ctrl.table_load;
  assign bit_avail = (bits_left != 6'h00);
  assign cur_bit = word[0];
  assign run_bit = !ctrl.runin_polarity_bit;
  assign ent = (runlen >= vlsd_pkg::RUNLEN_MAX) ? tbl[vlsd_pkg::TABLE_LAST]
                                                : tbl[runlen[2:0]];
  assign width = ctrl.uniform_en ? {2'h0, ctrl.uniform_width_field}
                                 : ent.pow_width;

  always_comb begin
    next_state = state;
    next_runlen = runlen;
    next_base = base;
    next_sfx = sfx;
    next_rem = rem;
    take = 1'b0;
    case (state)
      vlsd_pkg::ST_RUNIN: begin
        if (dec_en && bit_avail) begin
          take = 1'b1;
          if (cur_bit == run_bit) begin
            next_base = base + {9'h000, width};
            if (ctrl.term_en && ent.term_flag) begin
              next_rem = width;
              next_state = (width > vlsd_pkg::WIDTH_ONE) ? vlsd_pkg::ST_SUFFIX
                                                         : vlsd_pkg::ST_EMIT;
            end else if (runlen < vlsd_pkg::RUNLEN_MAX) begin
              next_runlen = runlen + 4'h1;
            end
          end else begin
            next_rem = width;
            next_state = (width > vlsd_pkg::WIDTH_ONE) ? vlsd_pkg::ST_SUFFIX
                                                       : vlsd_pkg::ST_EMIT;
          end
        end
      end
      vlsd_pkg::ST_SUFFIX: begin
        if (dec_en && bit_avail) begin
          take = 1'b1;
          next_sfx = {sfx[14:0], cur_bit};
          next_rem = {1'b0, rem[6:1]};
          if (rem == vlsd_pkg::WIDTH_TWO) begin
            next_state = vlsd_pkg::ST_EMIT;
          end
        end
      end
      vlsd_pkg::ST_EMIT: begin
        if (fifo_in_ready) begin
          next_state = vlsd_pkg::ST_RUNIN;
          next_runlen = '0;
          next_base = '0;
          next_sfx = '0;
          next_rem = '0;
        end
      end
      default: begin
        next_state = vlsd_pkg::ST_RUNIN;
        next_runlen = '0;
        next_base = '0;
        next_sfx = '0;
        next_rem = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= vlsd_pkg::ST_RUNIN;
      runlen <= '0;
      base <= '0;
      sfx <= '0;
      rem <= '0;
    end else begin
      state <= next_state;
      runlen <= next_runlen;
      base <= next_base;
      sfx <= next_sfx;
      rem <= next_rem;
    end
  end
endmodule // vlsd_top

// [vlsd_fifo.sv]
`timescale 1ns/10ps
module vlsd_fifo #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // ----------------------------------------
  // two-entry storage
  // ----------------------------------------
  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic wptr;
  logic rptr;
  logic [1:0] count;
  logic next_wptr;
  logic next_rptr;
  logic [1:0] next_count;
  logic do_push;
  logic do_pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (do_push) begin
      next_mem[wptr] = in_data;
      next_wptr = ~wptr;
    end
    if (do_pop) begin
      next_rptr = ~rptr;
    end
    if (do_push && !do_pop) begin
      next_count = count + 2'h1;
    end else if (!do_push && do_pop) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end
endmodule // vlsd_fifo

// [vlsd_reader.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// processor side: register bus master reading decoded values
// ------------------------------------------------------------
module vlsd_reader (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int slow;
  initial begin
    slow = 0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~v;
      end
    end
    repeat (slow) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one read; a slow reader stalls before taking the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (slow) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // vlsd_reader

// [vlsd_top_sva.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// register bus checker
// ------------------------------------------------------------
module vlsd_top_sva (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vlsd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic ar_hs;
  logic ar_bad;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ar_bad = s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > vlsd_pkg::ADDR_STATUS;
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  a_read_answer: assert property (ar_hs |=> s_axi_rvalid) else $error("read answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ctrl_reserved: assert property (ar_hs && s_axi_araddr == vlsd_pkg::ADDR_CTRL |=>
    s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14] && !s_axi_rdata[3])
    else $error("control reserved bits set");
  a_data_upper: assert property (ar_hs && s_axi_araddr == vlsd_pkg::ADDR_DATA |=>
    s_axi_rdata[30:16] == 15'h0000) else $error("data word upper bits set");
  a_unmapped_read: assert property (ar_hs && ar_bad |=>
    s_axi_rresp == vlsd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  c_unmapped: cover property (ar_hs && ar_bad);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == vlsd_pkg::RESP_SLVERR);
  c_value: cover property (s_axi_rvalid && s_axi_rdata[31]);
endmodule // vlsd_top_sva

bind vlsd_top vlsd_top_sva u_sva (.*);

// [vlsd_top_bench.sv]
`timescale 1ns/10ps
module vlsd_top_bench;
  // ------------------------------------------------------------
  // signals, design and processor-side model
  // ------------------------------------------------------------
  logic core_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_mismatch = 0;
  int tests_run = 0;
  vlsd_top dut (.*);
  vlsd_reader u_rd (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    u_rd.wr(a, v, r);
  endtask
  task automatic rreg(input logic [7:0] a);
    u_rd.rd(a, d, r);
  endtask
  function automatic logic [7:0] tab(input int i);
    return (i == 0) ? 8'h01 : (i < 4) ? 8'(1 << i) : (i == 7) ? 8'h88 : 8'h08;
  endfunction
  task automatic pop(input logic [15:0] v);
    d = 32'h0000_0000;
    for (int n = 0; n < 100 && d[31] !== 1'b1; n++) begin
      rreg(vlsd_pkg::ADDR_DATA);
    end
    check("decoded value", d, {16'h8000, v});
  endtask
  task automatic feed(input logic [31:0] w);
    d = 32'hFFFF_FFFF;
    for (int n = 0; n < 200 && d[7:2] !== 6'h00; n++) begin
      rreg(vlsd_pkg::ADDR_STATUS);
    end
    wreg(vlsd_pkg::ADDR_WORD, w);
    check("word taken", 32'(r), 32'(vlsd_pkg::RESP_OKAY));
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rreg(vlsd_pkg::ADDR_CTRL);
    check("control reset", d, 32'(vlsd_pkg::CTRL_RESET));
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_FFFF);
    rreg(vlsd_pkg::ADDR_CTRL);
    check("control fields", d, 32'h0000_BFF7);
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0000);
    rreg(8'h14);
    check("unmapped read", 32'(r), 32'(vlsd_pkg::RESP_SLVERR));
    wreg(8'h1C, 32'h0000_0010);
    check("unmapped write", 32'(r), 32'(vlsd_pkg::RESP_SLVERR));
  endtask
  task automatic t_end;
    logic [15:0] ex[9] = '{16'h0012, 16'h0008, 16'h0004, 16'h0000, 16'h0014,
      16'h000A, 16'h0000, 16'h0000, 16'h0000};
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0010);
    wreg(vlsd_pkg::ADDR_TABLE, 32'h0000_0001);
    wreg(vlsd_pkg::ADDR_TABLE, 32'h0000_0004);
    wreg(vlsd_pkg::ADDR_TABLE, 32'h0000_0088);
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0040);
    feed(32'h15FE_DCEF);
    foreach (ex[i]) pop(ex[i]);
  endtask
  task automatic t_packed;
    logic [3:0] nb;
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0010);
    wreg(vlsd_pkg::ADDR_TABLE, 32'h0000_0082);
    for (int p = 0; p < 2; p++) begin
      wreg(vlsd_pkg::ADDR_CTRL, 32'({p[0], 15'h08C0}));
      feed(32'hC3A5_1E96);
      for (int i = 0; i < 8; i++) begin
        nb = 4'(32'hC3A5_1E96 >> (4 * i));
        pop({12'h000, nb[0] ^ p[0], nb[1], nb[2], nb[3]});
      end
    end
  endtask
  task automatic t_table;
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0010);
    wreg(vlsd_pkg::ADDR_TABLE, 32'h0000_005A);
    for (int i = 1; i < 9; i++) wreg(vlsd_pkg::ADDR_TABLE, 32'(tab(i % 8)));
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0020);
    for (int i = 0; i < 9; i++) begin
      rreg(vlsd_pkg::ADDR_DATA);
      check("table entry", d, 32'(tab(i % 8)));
    end
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0020);
    rreg(vlsd_pkg::ADDR_DATA);
    check("first entry", d, 32'(tab(0)));
  endtask
  task automatic t_stream;
    logic [15:0] ex[20] = '{16'h0002, 16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0008, 16'h0001, 16'h0001, 16'h0005, 16'h000B, 16'h0004, 16'h0000,
      16'h000A, 16'h0002, 16'h0000, 16'h0000, 16'h000D, 16'h0000};
    wreg(vlsd_pkg::ADDR_CTRL, 32'h0000_0000);
    feed(32'hAC98_E14D);
    wreg(vlsd_pkg::ADDR_WORD, 32'h372E_74CB);
    check("busy word", 32'(r), 32'(vlsd_pkg::RESP_SLVERR));
    repeat (60) @(posedge core_clk);
    rreg(vlsd_pkg::ADDR_STATUS);
    check("buffer full", 32'(d[11:10]), 32'h0000_0002);
    u_rd.slow = 3;
    for (int i = 0; i < 20; i++) begin
      if (i == 11) feed(32'h372E_74CB);
      pop(ex[i]);
    end
    feed(32'h0000_15FF);
    pop(16'h003C);
    u_rd.slow = 0;
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_regs;
    t_end;
    t_packed;
    t_table;
    t_stream;
    stop_test;
  end
  initial begin
    #500000;
    n_mismatch++;
    stop_test;
  end
endmodule // vlsd_top_bench
